// ---- rtl/shr_pkg.sv ----
// Constants and carrier types for the line-sharing arbiter
//------------------------------------------------------------
// Overview of operation
// R1: Transmit timing from internal 48 or 64 kbps or sub-channel 1 clock; default 64.
// R2: Main-channel timing ignores the rate setting and follows the main modem clock.
// R3: Contention setting picks control-signal or data-activity selection; control is default.
// R4: Indication to sub-channels mirrors main-channel input or stays on; mirror default.
// R5: Indication to main mirrors the connected sub-channel or stays on; mirror default.
// R6: Streaming sub-channel auto-disabled after 32.4, 4 or 0.5 s, or never; 32.4 default.
// R7: Extra buffer switch covers all four sub-channels together; off by default.
// R8: Extra buffer absorbs phase offset between sub-channel data and transmit clock.
// R9: With sub-channel 1 timing, main equipment must not be an internally clocked modem.
// R10: With internal or sub-channel 1 timing, main modem takes the clock we drive.
// R11: With sub-channel 1 timing, its modem runs on internal or receive clock.
// R12: Each channel configurable as terminal or line side; terminal side by default.
// R13: Data contention grants the highest active sub-channel; 4 highest, 1 lowest.
// R14: Data contention releases the connected sub-channel after 16 consecutive idle bits.
// R15: Auto-disable clears when that sub-channel drops control or sends 16 idle bits.
// R16: Selected sub-channel drives main; main receive data fans out to all sub-channels.
// R17: Streaming timer runs only while connected and restarts at each new connection.
//------------------------------------------------------------
package shr_pkg;
  //------------------------------------------------------------
  // Timing
  //------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int RATE64_KBPS = 64;
  localparam int RATE48_KBPS = 48;
  localparam int HALF64_CYC = CLK_KHZ / (2 * RATE64_KBPS);
  localparam int HALF48_CYC = CLK_KHZ / (2 * RATE48_KBPS);
  // Limits in tenths of a second
  localparam int TOUT_LONG_DS = 324;
  localparam int TOUT_MID_DS = 40;
  localparam int TOUT_SHORT_DS = 5;
  localparam int TOUT_LONG_CYC = TOUT_LONG_DS * CLK_KHZ * 100;
  localparam int TOUT_MID_CYC = TOUT_MID_DS * CLK_KHZ * 100;
  localparam int TOUT_SHORT_CYC = TOUT_SHORT_DS * CLK_KHZ * 100;
  localparam int IDLE_BITS = 16;
  localparam int XBUF_BITS = 2;
  //------------------------------------------------------------
  // Register map
  //------------------------------------------------------------
  localparam int CFG_W = 13;
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] DIS_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;
  localparam logic [3:0] DIS_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  //------------------------------------------------------------
  // Types
  //------------------------------------------------------------
  typedef enum logic [1:0] {CLK_INT64, CLK_INT48, CLK_SUB1, CLK_MAIN} clk_src_e;
  typedef enum logic [1:0] {TOUT_LONG, TOUT_MID, TOUT_SHORT, TOUT_OFF} tout_e;
  typedef enum logic {ARB_IDLE, ARB_CONN} arb_e;
  typedef struct packed {
    logic [4:0] role;
    logic xbuf;
    tout_e tout;
    logic ci_main_on;
    logic ci_sub_on;
    logic data_mode;
    clk_src_e clk;
  } cfg_s;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_s;
endpackage

// ---- rtl/line_sharing_arbiter.sv ----
// Four-way sub-channel sharer for one synchronous main channel
module line_sharing_arbiter #(
  parameter int LONG_TOUT_CYC = shr_pkg::TOUT_LONG_CYC,
  parameter int MID_TOUT_CYC = shr_pkg::TOUT_MID_CYC,
  parameter int SHORT_TOUT_CYC = shr_pkg::TOUT_SHORT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic LINK_CLK_I,
  input wire shr_pkg::axi_req_s AXI_REQ_I,
  output shr_pkg::axi_rsp_s AXI_RSP_O,
  input wire logic [3:0] SUB_TXD_I,
  input wire logic [3:0] SUB_CTL_I,
  input wire logic SUB1_CLK_I,
  input wire logic MAIN_RXD_I,
  input wire logic MAIN_CI_I,
  output logic MAIN_TXD_O,
  output logic MAIN_CTL_O,
  output logic [3:0] SUB_RXD_O,
  output logic [3:0] SUB_CI_O,
  output logic TX_CLK_O,
  output logic [4:0] ROLE_DCE_O,
  output logic [3:0] AUTO_DIS_O
);
  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef struct packed {
    shr_pkg::axi_rsp_s rsp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    shr_pkg::cfg_s cfg;
    logic [3:0] man_dis;
    logic [11:0] s1;
    logic [11:0] s2;
    logic lt_prev;
    logic c1_prev;
    logic [8:0] div;
    logic tx_clk;
    logic [3:0][4:0] idle;
    logic [3:0] heard;
    shr_pkg::arb_e arb;
    logic [1:0] sel;
    logic [30:0] tmr;
    logic [3:0] auto_dis;
    logic [shr_pkg::XBUF_BITS-1:0] dly;
    logic main_txd;
    logic main_ctl;
    logic [3:0] sub_rxd;
    logic [3:0] sub_ci;
    logic [4:0] role;
    logic live;
  } st_s;

  st_s s;
  st_s n;
  logic link_tgl;
  logic [3:0] txd;
  logic [3:0] ctl;
  logic c1;
  logic mrxd;
  logic mci;
  logic lt;
  logic tick;
  logic [3:0] quiet;
  logic [3:0] cand;
  logic [8:0] half;
  logic [30:0] lim;
  logic [shr_pkg::CFG_W-1:0] c;
  logic conn;

  //------------------------------------------------------------
  // Link clock domain
  //------------------------------------------------------------
  // One toggle per rising main-modem clock edge; crosses as an event
  // Only sound while the link clock stays below CLK_I; faster edges alias
  always_ff @(posedge LINK_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      link_tgl <= 1'b0;
    end else begin
      link_tgl <= ~link_tgl;
    end
  end

  assign txd = s.s2[3:0];
  assign ctl = s.s2[7:4];
  assign c1 = s.s2[8];
  assign mrxd = s.s2[9];
  assign mci = s.s2[10];
  assign lt = s.s2[11];
  assign conn = (s.arb == shr_pkg::ARB_CONN);

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb begin
    n = s;
    c = s.cfg;
    n.s1 = {link_tgl, MAIN_CI_I, MAIN_RXD_I, SUB1_CLK_I, SUB_CTL_I, SUB_TXD_I};
    n.s2 = s.s1;
    n.lt_prev = lt;
    n.c1_prev = c1;
    n.live = 1'b1;
    tick = 1'b0;
    if (s.cfg.clk == shr_pkg::CLK_INT48) begin
      half = 9'(shr_pkg::HALF48_CYC - 1);
    end else begin
      half = 9'(shr_pkg::HALF64_CYC - 1);
    end
    // Bit timing source
    case (s.cfg.clk)
      shr_pkg::CLK_MAIN: begin
        n.tx_clk = 1'b0; // R2
        n.div = 9'h000;
        tick = lt ^ s.lt_prev; // R2
      end
      shr_pkg::CLK_SUB1: begin
        n.tx_clk = c1; // R1
        n.div = 9'h000;
        tick = c1 & ~s.c1_prev; // R1
      end
      default: begin
        if (s.div >= half) begin
          n.div = 9'h000;
          n.tx_clk = ~s.tx_clk; // R1
          tick = ~s.tx_clk;
        end else begin
          n.div = s.div + 9'h001;
        end
      end
    endcase
    // Per sub-channel activity
    for (int i = 0; i < 4; i++) begin
      if (tick) begin
        if (!txd[i]) begin
          n.idle[i] = 5'h00;
          n.heard[i] = 1'b1;
        end else if (s.idle[i] < 5'(shr_pkg::IDLE_BITS)) begin
          n.idle[i] = s.idle[i] + 5'h01;
          if (s.idle[i] == 5'(shr_pkg::IDLE_BITS - 1)) begin
            n.heard[i] = 1'b0; // R14
          end
        end
      end
      quiet[i] = s.cfg.data_mode ? ~s.heard[i] : ~ctl[i]; // R3
      cand[i] = ~quiet[i] & ~s.man_dis[i] & ~s.auto_dis[i];
      if (quiet[i]) begin
        n.auto_dis[i] = 1'b0; // R15
      end
    end
    case (s.cfg.tout)
      shr_pkg::TOUT_MID: lim = 31'(MID_TOUT_CYC);
      shr_pkg::TOUT_SHORT: lim = 31'(SHORT_TOUT_CYC);
      default: lim = 31'(LONG_TOUT_CYC);
    endcase
    // Arbiter
    case (s.arb)
      shr_pkg::ARB_IDLE: begin
        n.tmr = 31'h00000000; // R17
        // Later index overrides, so sub-channel 4 wins
        for (int i = 0; i < 4; i++) begin
          if (cand[i]) begin
            n.sel = 2'(i); // R13
            n.arb = shr_pkg::ARB_CONN;
          end
        end
      end
      shr_pkg::ARB_CONN: begin
        n.tmr = s.tmr + 31'h00000001; // R17
        if (quiet[s.sel] || s.man_dis[s.sel]) begin
          n.arb = shr_pkg::ARB_IDLE; // R14
        end else if (s.cfg.tout != shr_pkg::TOUT_OFF && s.tmr >= lim - 31'h00000001) begin
          n.auto_dis[s.sel] = 1'b1; // R6
          n.arb = shr_pkg::ARB_IDLE;
        end
      end
      default: n.arb = shr_pkg::ARB_IDLE;
    endcase
    // Retiming stage for sub-channels that bring their own clock
    if (tick) begin
      n.dly = {s.dly[shr_pkg::XBUF_BITS-2:0], txd[s.sel]}; // R8
    end
    if (conn) begin
      n.main_txd = s.cfg.xbuf ? s.dly[shr_pkg::XBUF_BITS-1] : txd[s.sel]; // R7 R16
    end else begin
      n.main_txd = 1'b1;
    end
    n.main_ctl = s.cfg.ci_main_on | (conn & ctl[s.sel]); // R5 R16
    n.sub_rxd = {4{mrxd}}; // R16
    n.sub_ci = s.cfg.ci_sub_on ? 4'hF : {4{mci}}; // R4
    n.role = s.cfg.role; // R12
    //------------------------------------------------------------
    // Register slave
    //------------------------------------------------------------
    if (s.rsp.awready && AXI_REQ_I.awvalid) begin
      n.aw_got = 1'b1;
      n.waddr = AXI_REQ_I.awaddr;
    end
    if (s.rsp.wready && AXI_REQ_I.wvalid) begin
      n.w_got = 1'b1;
      n.wdata = AXI_REQ_I.wdata;
      n.wstrb = AXI_REQ_I.wstrb;
    end
    if (s.rsp.bvalid && AXI_REQ_I.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = shr_pkg::RESP_OKAY;
      case (s.waddr)
        shr_pkg::CFG_OFF: begin
          if (s.wstrb[0]) begin
            c[7:0] = s.wdata[7:0];
            // A new rate starts a full half period, never a runt one
            if (s.wdata[1:0] != s.cfg.clk) begin
              n.div = 9'h000; // R1
            end
          end
          if (s.wstrb[1]) begin
            c[12:8] = s.wdata[12:8];
          end
        end
        shr_pkg::DIS_OFF: begin
          if (s.wstrb[0]) begin
            n.man_dis = s.wdata[3:0];
          end
        end
        shr_pkg::STAT_OFF: begin
        end
        default: n.rsp.bresp = shr_pkg::RESP_SLVERR;
      endcase
      n.cfg = shr_pkg::cfg_s'(c);
    end
    if (s.rsp.arready && AXI_REQ_I.arvalid) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = shr_pkg::RESP_OKAY;
      case (AXI_REQ_I.araddr)
        shr_pkg::CFG_OFF: n.rsp.rdata = {19'h00000, s.cfg};
        shr_pkg::DIS_OFF: n.rsp.rdata = {28'h0000000, s.man_dis};
        shr_pkg::STAT_OFF: n.rsp.rdata = {24'h000000, s.auto_dis, 1'b0, conn, s.sel};
        default: begin
          n.rsp.rdata = 32'h00000000;
          n.rsp.rresp = shr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s.rsp.rvalid && AXI_REQ_I.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    // One write and one read in flight; ready drops until the answer is taken
    n.rsp.awready = ~n.aw_got & ~n.rsp.bvalid;
    n.rsp.wready = ~n.w_got & ~n.rsp.bvalid;
    n.rsp.arready = ~n.rsp.rvalid;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s <= '0;
      s.cfg <= shr_pkg::cfg_s'(shr_pkg::CFG_RST);
      s.man_dis <= shr_pkg::DIS_RST;
    end else begin
      s <= n;
    end
  end

  assign AXI_RSP_O = s.rsp;
  assign MAIN_TXD_O = s.main_txd;
  assign MAIN_CTL_O = s.main_ctl;
  assign SUB_RXD_O = s.sub_rxd;
  assign SUB_CI_O = s.sub_ci;
  assign TX_CLK_O = s.tx_clk;
  assign ROLE_DCE_O = s.role;
  assign AUTO_DIS_O = s.auto_dis;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I || !s.live);

  chk_int_rate_div: assert property ( // R1
    (s.cfg.clk == shr_pkg::CLK_INT64 && $stable(s.cfg) && $rose(s.tx_clk))
      |-> $past(s.div) == 9'(shr_pkg::HALF64_CYC - 1))
    else $error("internal clock half period wrong");
  chk_main_clk_quiet: assert property ( // R2
    s.cfg.clk == shr_pkg::CLK_MAIN |=> !TX_CLK_O)
    else $error("clock driven in main timing mode");
  chk_ctl_release: assert property ( // R3
    (conn && !s.cfg.data_mode && !ctl[s.sel]) |=> s.arb == shr_pkg::ARB_IDLE)
    else $error("not released on control drop");
  chk_ci_sub_on: assert property ( // R4
    s.cfg.ci_sub_on |=> SUB_CI_O == 4'hF)
    else $error("sub indication not held on");
  chk_ci_main_on: assert property ( // R5
    s.cfg.ci_main_on |=> MAIN_CTL_O)
    else $error("main indication not held on");
  chk_auto_cause: assert property ( // R6
    |(s.auto_dis & ~$past(s.auto_dis))
      |-> $past(conn) && $past(s.tmr) >= $past(lim) - 31'h00000001)
    else $error("auto disable without timeout");
  chk_tout_off: assert property ( // R6
    s.cfg.tout == shr_pkg::TOUT_OFF |=> (s.auto_dis & ~$past(s.auto_dis)) == 4'h0)
    else $error("auto disable while timeout off");
  chk_top_prio: assert property ( // R13
    (s.arb == shr_pkg::ARB_IDLE && cand[3]) |=> conn && s.sel == 2'h3)
    else $error("highest sub-channel not granted");
  chk_idle_release: assert property ( // R14
    (conn && s.cfg.data_mode && quiet[s.sel]) |=> s.arb == shr_pkg::ARB_IDLE)
    else $error("not released after idle bits");
  chk_auto_clear: assert property ( // R15
    |(s.auto_dis & quiet) |=> ($past(s.auto_dis & quiet) & s.auto_dis) == 4'h0)
    else $error("auto disable not cleared");
  chk_rxd_fanout: assert property ( // R16
    MAIN_RXD_I [*4] |-> SUB_RXD_O == 4'hF)
    else $error("receive data not fanned out");
  chk_timer_start: assert property ( // R17
    $rose(conn) |-> s.tmr == 31'h00000000 ##1 s.tmr == 31'h00000001)
    else $error("timer not restarted");
  chk_rate48_div: assert property ( // R1
    (s.cfg.clk == shr_pkg::CLK_INT48 && $stable(s.cfg) && $rose(s.tx_clk))
      |-> $past(s.div) == 9'(shr_pkg::HALF48_CYC - 1))
    else $error("48k half period wrong");
  chk_rxd_fanout_lo: assert property ( // R16
    (!MAIN_RXD_I) [*4] |-> SUB_RXD_O == 4'h0)
    else $error("receive space not fanned out");
  chk_sel_hold: assert property ( // R16
    (conn && $past(conn)) |-> $stable(s.sel))
    else $error("selection changed while connected");
  chk_txd_route: assert property ( // R16
    (conn && !s.cfg.xbuf) |=> MAIN_TXD_O == $past(txd[s.sel]))
    else $error("selected data not routed");
  chk_txd_mark: assert property ( // R16
    !conn |=> MAIN_TXD_O)
    else $error("main data not idle when free");
  chk_ci_sub_mirror: assert property ( // R4
    !s.cfg.ci_sub_on |=> SUB_CI_O == {4{$past(mci)}})
    else $error("sub indication not mirrored");
  chk_ci_main_mirror: assert property ( // R5
    !s.cfg.ci_main_on |=> MAIN_CTL_O == $past(conn && ctl[s.sel]))
    else $error("main indication not mirrored");
  chk_timer_idle: assert property ( // R17
    !conn |=> s.tmr == 31'h00000000)
    else $error("timer runs while free");
endmodule

// ---- tb/sub_equipment.sv ----
// Behavioural model of the four sub-channel terminals or modems
module sub_equipment #(
  parameter int HALF_CYC = 300
) (
  input wire logic clk_i,
  input wire logic [3:0] want_i,
  input wire logic [3:0] send_i,
  output logic [3:0] ctl_o,
  output logic [3:0] txd_o,
  output logic sub1_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  //------------------------------------------------------------
  // Line behaviour
  //------------------------------------------------------------
  int div = 0;
  initial begin
    ctl_o = 4'h0;
    txd_o = 4'hF;
    sub1_clk_o = 1'b0;
  end
  // Idle terminals hold mark; a space only while told to send
  always @(posedge clk_i) begin
    ctl_o <= want_i;
    txd_o <= ~send_i;
    div <= (div == HALF_CYC - 1) ? 0 : div + 1;
    // Sub-channel 1 modem runs free on its own clock as the reference
    if (div == 0) begin
      sub1_clk_o <= ~sub1_clk_o;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the line-sharing arbiter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  //------------------------------------------------------------
  // Signals and instances
  //------------------------------------------------------------
  localparam int TOUT [3] = '{200, 100, 50};
  // Half period of the sub-channel 1 reference, in system cycles
  localparam int SUB1_HALF = 300;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  shr_pkg::axi_req_s req = '0;
  shr_pkg::axi_rsp_s rsp;
  logic [3:0] want = 4'h0;
  logic [3:0] send = 4'h0;
  logic [3:0] ctl, txd, sub_rxd, sub_ci, auto_dis;
  logic sub1_clk, main_txd, main_ctl, tx_clk;
  logic main_rxd = 1'b1;
  logic main_ci = 1'b0;
  logic [4:0] role;
  logic [31:0] rd;
  logic [1:0] resp;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  // Main-side clock; only heeded in main timing mode
  always #7.5 link_clk = ~link_clk;
  line_sharing_arbiter #(.LONG_TOUT_CYC(TOUT[0]), .MID_TOUT_CYC(TOUT[1]),
    .SHORT_TOUT_CYC(TOUT[2])) i_line_sharing_arbiter (.CLK_I(clk), .RST_B_I(rst_b),
    .LINK_CLK_I(link_clk), .AXI_REQ_I(req), .AXI_RSP_O(rsp), .SUB_TXD_I(txd),
    .SUB_CTL_I(ctl), .SUB1_CLK_I(sub1_clk), .MAIN_RXD_I(main_rxd), .MAIN_CI_I(main_ci),
    .MAIN_TXD_O(main_txd), .MAIN_CTL_O(main_ctl), .SUB_RXD_O(sub_rxd), .SUB_CI_O(sub_ci),
    .TX_CLK_O(tx_clk), .ROLE_DCE_O(role), .AUTO_DIS_O(auto_dis));
  sub_equipment #(.HALF_CYC(SUB1_HALF)) i_sub_equipment (.clk_i(clk), .want_i(want),
    .send_i(send), .ctl_o(ctl),
    .txd_o(txd), .sub1_clk_o(sub1_clk));
  //------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------
  task automatic final_report();
    $display("Counts: %0d compares, %0d errors", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: pins %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    resp = rsp.bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ar;
    ar = 1'b1;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar && rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (ar || rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    resp = rsp.rresp;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rd_reg(a);
    cmp_word(rd, d);
    cmp_word({30'h0, resp}, {30'h0, r});
  endtask
  // System clock cycles between two toggles of the transmit clock
  task automatic meas(output int n);
    logic v;
    n = 0;
    v = tx_clk;
    do begin
      @(posedge clk);
      n++;
    end while (tx_clk === v);
  endtask
  // A hang must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      final_report();
    end
  end
  //------------------------------------------------------------
  // Tests
  //------------------------------------------------------------
  initial begin
    int n;
    cyc(10);
    rst_b <= 1'b1;
    cyc(2);
    chk_rd(shr_pkg::CFG_OFF, 32'(shr_pkg::CFG_RST), shr_pkg::RESP_OKAY);
    chk_rd(shr_pkg::DIS_OFF, 32'h0, shr_pkg::RESP_OKAY);
    chk_rd(8'h0C, 32'h0, shr_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1);
    cmp_word({30'h0, resp}, {30'h0, shr_pkg::RESP_SLVERR});
    wr(shr_pkg::DIS_OFF, 32'h5);
    chk_rd(shr_pkg::DIS_OFF, 32'h5, shr_pkg::RESP_OKAY);
    wr(shr_pkg::DIS_OFF, 32'h0);
    $display("Test registers done");
    meas(n);
    meas(n);
    cmp_word(32'(n), 32'(shr_pkg::HALF64_CYC));
    wr(shr_pkg::CFG_OFF, 32'h1);
    meas(n);
    meas(n);
    cmp_word(32'(n), 32'(shr_pkg::HALF48_CYC));
    // Switching source may jump the clock once, so the third half is the clean one
    wr(shr_pkg::CFG_OFF, 32'h2);
    meas(n);
    meas(n);
    meas(n);
    cmp_word(32'(n), 32'(SUB1_HALF));
    wr(shr_pkg::CFG_OFF, 32'h3);
    cyc(8);
    cmp_pin({4'h0, tx_clk}, 5'h0);
    wr(shr_pkg::CFG_OFF, 32'h1F00);
    cyc(3);
    cmp_pin(role, 5'h1F);
    wr(shr_pkg::CFG_OFF, 32'h0);
    $display("Test clocks done");
    main_rxd <= 1'b0;
    main_ci <= 1'b1;
    cyc(6);
    cmp_pin({1'b0, sub_rxd}, 5'h0);
    cmp_pin({1'b0, sub_ci}, 5'hF);
    main_rxd <= 1'b1;
    main_ci <= 1'b0;
    cyc(6);
    cmp_pin({sub_rxd, main_ctl}, 5'h1E);
    wr(shr_pkg::CFG_OFF, 32'h18);
    cyc(6);
    cmp_pin({sub_ci, main_ctl}, 5'h1F);
    wr(shr_pkg::CFG_OFF, 32'h0);
    $display("Test indication done");
    // Sub 4 outranks sub 2 when both raise control together
    send <= 4'h8;
    want <= 4'hA;
    cyc(8);
    chk_rd(shr_pkg::STAT_OFF, 32'h7, shr_pkg::RESP_OKAY);
    cmp_pin({3'h0, main_txd, main_ctl}, 5'h1);
    want <= 4'h0;
    send <= 4'h0;
    cyc(8);
    cmp_pin({3'h0, main_txd, main_ctl}, 5'h2);
    $display("Test control contention done");
    for (int k = 0; k < 3; k++) begin
      wr(shr_pkg::CFG_OFF, 32'(k) << 5);
      want <= 4'h4;
      cyc(TOUT[k] - 14);
      cmp_pin({1'b0, auto_dis}, 5'h0);
      cyc(40);
      cmp_pin({1'b0, auto_dis}, 5'h4);
      want <= 4'h0;
      cyc(8);
      cmp_pin({1'b0, auto_dis}, 5'h0);
    end
    wr(shr_pkg::CFG_OFF, 32'h60);
    want <= 4'h4;
    cyc(260);
    cmp_pin({1'b0, auto_dis}, 5'h0);
    want <= 4'h0;
    $display("Test streaming limit done");
    // Buffer delays data by whole bit times, so the first cycles still show mark
    wr(shr_pkg::CFG_OFF, 32'hE0);
    send <= 4'h8;
    want <= 4'h8;
    cyc(8);
    cmp_pin({4'h0, main_txd}, 5'h1);
    cyc(3 * 2 * shr_pkg::HALF64_CYC);
    cmp_pin({4'h0, main_txd}, 5'h0);
    want <= 4'h0;
    send <= 4'h0;
    $display("Test extra buffer done");
    wr(shr_pkg::CFG_OFF, 32'h64);
    send <= 4'hA;
    cyc(4 * shr_pkg::HALF64_CYC);
    chk_rd(shr_pkg::STAT_OFF, 32'h7, shr_pkg::RESP_OKAY);
    send <= 4'h0;
    cyc(14 * 2 * shr_pkg::HALF64_CYC);
    rd_reg(shr_pkg::STAT_OFF);
    cmp_word(rd & 32'h4, 32'h4);
    cyc(4 * 2 * shr_pkg::HALF64_CYC);
    rd_reg(shr_pkg::STAT_OFF);
    cmp_word(rd & 32'h4, 32'h0);
    $display("Test data contention done");
    final_report();
  end
endmodule
